/* mbcd_defs.svh */
/*
 Constants for the mic bias current detect block: register addresses, field positions,
 reset values and timing counts.
 Assumes it is included by its bare name from the package, which the design modules import.
*/
`ifndef MBCD_DEFS_SVH
`define MBCD_DEFS_SVH
`define MBCD_ADDR_PWR1 8'h19
`define MBCD_ADDR_LVL 8'h30
`define MBCD_ADDR_ACC 8'h31
`define MBCD_ADDR_IRQ 8'h32
`define MBCD_BIT_BIAS_EN 1
`define MBCD_BIT_BIAS_LVL 0
`define MBCD_BIT_DET_EN 9
`define MBCD_ACC_THR_HI 14
`define MBCD_ACC_THR_LO 12
`define MBCD_SHT_THR_HI 11
`define MBCD_SHT_THR_LO 10
`define MBCD_BIT_ACC_STS 7
`define MBCD_BIT_SHT_STS 6
`define MBCD_BIT_ACC_POL 0
`define MBCD_BIT_SHT_POL 1
`define MBCD_BIT_ACC_IRQ 4
`define MBCD_BIT_SHT_IRQ 5
`define MBCD_BIT_SYSTEM_CLOCK_EN 2
`define MBCD_BIT_GPIO_SEL 3
`define MBCD_RST_LVL 1'b1
`define MBCD_RST_ZERO 16'h0000
`define MBCD_FILT_COUNT 4'ha
`define MBCD_SAMPLE_NS 10000
`define MBCD_CLK_NS 10
`define MBCD_SAMPLE_CYC (`MBCD_SAMPLE_NS / `MBCD_CLK_NS)
`define MBCD_ACC_SETTLE 4'h4
`endif

/* mbcd_pkg.sv */
/*
 Types shared by the mic bias current detect block.
 Assumes mbcd_defs.svh is on the include path.
*/
`include "mbcd_defs.svh"
package mbcd_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } mbcd_req_s;
  typedef struct packed {
    logic acc_above;
    logic sht_above;
  } mbcd_cmp_s;
  typedef enum logic [1:0] {
    MBCD_IDLE = 2'b00,
    MBCD_COUNT = 2'b01,
    MBCD_HELD = 2'b11
  } mbcd_filt_e;
endpackage : mbcd_pkg

/* mbcd_sync.sv */
/*
 Two flip-flop synchroniser for the analogue comparator levels.
 Assumes the comparator outputs are asynchronous to clock.
*/
`timescale 1ns/1ps
module mbcd_sync import mbcd_pkg::*; (
  input wire logic clock,
  input wire logic rst_n,
  input wire mbcd_cmp_s async_in,
  output mbcd_cmp_s sync_out
);
  typedef struct packed {
    mbcd_cmp_s s1;
    mbcd_cmp_s s2;
  } mbcd_sync_st_s;
  mbcd_sync_st_s st_reg;
  mbcd_sync_st_s st_next;
  always_comb begin
    st_next.s1 = async_in;
    st_next.s2 = st_reg.s1;
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign sync_out = st_reg.s2;
endmodule : mbcd_sync

/* mbcd_filter.sv */
/*
 Consecutive-measurement filter for the short comparison.
 Assumes sample_tick is a one-cycle enable that only pulses while the system clock runs.
*/
`timescale 1ns/1ps
module mbcd_filter import mbcd_pkg::*; (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic sample_tick,
  input wire logic raw_in,
  output logic filt_out
);
  typedef struct packed {
    mbcd_filt_e state;
    logic [3:0] count;
    logic out;
  } mbcd_filt_st_s;
  mbcd_filt_st_s st_reg;
  mbcd_filt_st_s st_next;
  always_comb begin
    st_next = st_reg;
    if (sample_tick) begin
      case (st_reg.state)
        MBCD_IDLE: begin
          if (raw_in) begin
            st_next.state = MBCD_COUNT;
            st_next.count = 4'h1;
          end
        end
        MBCD_COUNT: begin
          if (!raw_in) begin
            st_next.state = MBCD_IDLE;
            st_next.count = 4'h0;
          end else if (st_reg.count == `MBCD_FILT_COUNT - 4'h1) begin
            st_next.state = MBCD_HELD;
            st_next.out = 1'b1;
          end else begin
            st_next.count = st_reg.count + 4'h1;
          end
        end
        MBCD_HELD: begin
          if (!raw_in) begin
            st_next.state = MBCD_IDLE;
            st_next.count = 4'h0;
            st_next.out = 1'b0;
          end
        end
        default: begin
          st_next.state = MBCD_IDLE;
          st_next.count = 4'h0;
          st_next.out = 1'b0;
        end
      endcase
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign filt_out = st_reg.out;
endmodule : mbcd_filter

/* mbcd_top.sv */
/*
 Mic bias control and current detect: bias enable and level, threshold selects,
 live status, short filter, polarity-selected event flags and GPIO level output.
 The bias pin enable is active low and changes on the same edge as the drive level.
 Assumes a simple synchronous register port, analogue comparators that report
 against the thresholds driven here, and a system clock presence level.
*/
//
// Contract
// - Drive bias only when enable bit set.
// - Level bit selects five or seven sixths.
// - Bit 9 enables both current comparisons.
// - Three-bit accessory threshold at bits 14:12.
// - Two-bit short threshold at bits 11:10.
// - Accessory status bit 7 tracks comparison.
// - Short status bit 6 tracks comparison.
// - Short event after ten consecutive measurements.
// - Polarity 0 flags accessory insertion.
// - Polarity 1 flags accessory removal.
// - Polarity 0 flags filtered hook press.
// - Polarity 1 flags hook release.
// - Detections feed interrupts and GPIO level.
// - Filter runs only with clock present, enabled.
// - Events during no clock detected later.
// - Accessory detection bandwidth limited, bounded delay.
`timescale 1ns/1ps
module mbcd_top import mbcd_pkg::*; (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_ack,
  input wire logic clock_source_present,
  input wire logic comp_acc_above,
  input wire logic comp_sht_above,
  output logic mic_bias_output_drive,
  output logic mic_bias_output_oe_n,
  output logic bias_level_select,
  output logic current_detect_enable,
  output logic [2:0] accessory_threshold,
  output logic [1:0] short_threshold,
  output logic accessory_event,
  output logic short_event,
  output logic gpio_detect_level
);
  typedef struct packed {
    logic bias_en;
    logic bias_lvl;
    logic det_en;
    logic [2:0] acc_thr;
    logic [1:0] sht_thr;
    logic acc_pol;
    logic sht_pol;
    logic system_clock_en;
    logic gpio_sel;
    logic acc_irq;
    logic sht_irq;
    logic acc_sts;
    logic sht_sts;
    logic acc_state;
    logic sht_state;
    logic [3:0] acc_settle;
    logic [13:0] div_cnt;
    logic tick;
    logic [15:0] rdata;
    logic ack;
    logic acc_ev;
    logic sht_ev;
    logic gpio;
    logic oe_n;
  } mbcd_top_st_s;
  mbcd_top_st_s st_reg;
  mbcd_top_st_s st_next;
  mbcd_cmp_s cmp_raw;
  mbcd_cmp_s cmp_sync;
  logic sht_filt;
  logic clk_ok;

  // Register view of the accessory detect control word, used by reads.
  function automatic logic [15:0] mbcd_acc_word(input mbcd_top_st_s s);
    logic [15:0] w;
    w = `MBCD_RST_ZERO;
    w[`MBCD_ACC_THR_HI:`MBCD_ACC_THR_LO] = s.acc_thr;
    w[`MBCD_SHT_THR_HI:`MBCD_SHT_THR_LO] = s.sht_thr;
    w[`MBCD_BIT_DET_EN] = s.det_en;
    w[`MBCD_BIT_ACC_STS] = s.acc_sts;
    w[`MBCD_BIT_SHT_STS] = s.sht_sts;
    return w;
  endfunction : mbcd_acc_word

  // Polarity picks which edge of a detection raises its flag.
  function automatic logic mbcd_event_sel(input logic pol, input logic rise, input logic fall);
    return pol ? fall : rise;
  endfunction : mbcd_event_sel

  // Write-one-to-clear flag: a set in the same cycle as its clear wins.
  function automatic logic mbcd_flag_next(input logic set_now, input logic held,
    input logic clr_now);
    return set_now | (held & ~clr_now);
  endfunction : mbcd_flag_next

  // Register view of the power word; only the bits this block owns read back.
  function automatic logic [15:0] mbcd_pwr1_word(input mbcd_top_st_s s);
    logic [15:0] w;
    w = `MBCD_RST_ZERO;
    w[`MBCD_BIT_BIAS_EN] = s.bias_en;
    w[`MBCD_BIT_SYSTEM_CLOCK_EN] = s.system_clock_en;
    return w;
  endfunction : mbcd_pwr1_word

  // Register view of the bias level word.
  function automatic logic [15:0] mbcd_lvl_word(input mbcd_top_st_s s);
    logic [15:0] w;
    w = `MBCD_RST_ZERO;
    w[`MBCD_BIT_BIAS_LVL] = s.bias_lvl;
    return w;
  endfunction : mbcd_lvl_word

  // Register view of the polarity, flag and output select word.
  function automatic logic [15:0] mbcd_irq_word(input mbcd_top_st_s s);
    logic [15:0] w;
    w = `MBCD_RST_ZERO;
    w[`MBCD_BIT_ACC_POL] = s.acc_pol;
    w[`MBCD_BIT_SHT_POL] = s.sht_pol;
    w[`MBCD_BIT_GPIO_SEL] = s.gpio_sel;
    w[`MBCD_BIT_ACC_IRQ] = s.acc_irq;
    w[`MBCD_BIT_SHT_IRQ] = s.sht_irq;
    return w;
  endfunction : mbcd_irq_word

  assign cmp_raw.acc_above = comp_acc_above;
  assign cmp_raw.sht_above = comp_sht_above;

  // Comparator levels come from the analogue side, so they pass two flops first.
  mbcd_sync u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in(cmp_raw),
    .sync_out(cmp_sync)
  );

  // The filter only sees sample ticks while the system clock is usable.
  assign clk_ok = st_reg.system_clock_en & st_reg.det_en;

  mbcd_filter u_filter (
    .clock(clock),
    .rst_n(rst_n),
    .sample_tick(st_reg.tick),
    .raw_in(cmp_sync.sht_above & st_reg.det_en),
    .filt_out(sht_filt)
  );

  always_comb begin
    logic acc_live;
    logic sht_live;
    logic acc_rise;
    logic acc_fall;
    logic sht_rise;
    logic sht_fall;
    logic acc_set;
    logic sht_set;
    logic [15:0] clr;
    acc_rise = 1'b0;
    acc_fall = 1'b0;
    sht_rise = 1'b0;
    sht_fall = 1'b0;
    acc_set = 1'b0;
    sht_set = 1'b0;
    clr = `MBCD_RST_ZERO;
    acc_live = cmp_sync.acc_above & st_reg.det_en;
    sht_live = cmp_sync.sht_above & st_reg.det_en;
    st_next = st_reg;
    st_next.ack = 1'b0;
    st_next.acc_ev = 1'b0;
    st_next.sht_ev = 1'b0;
    st_next.acc_sts = acc_live;
    st_next.sht_sts = sht_live;

    // Sample clock divider; ticks only while the clock criteria hold.
    st_next.tick = 1'b0;
    if (clk_ok && clock_source_present) begin
      if (st_reg.div_cnt == 14'(`MBCD_SAMPLE_CYC - 1)) begin
        st_next.div_cnt = 14'h0000;
        st_next.tick = 1'b1;
      end else begin
        st_next.div_cnt = st_reg.div_cnt + 14'h0001;
      end
    end

    // Accessory debounce: the state moves only after the level has stood for several
    // sample ticks, which limits bandwidth. With no clock nothing moves, and the first
    // ticks after it returns still see the changed level, so the event is not lost.
    if (st_reg.tick) begin
      if (acc_live != st_reg.acc_state) begin
        if (st_reg.acc_settle == `MBCD_ACC_SETTLE - 4'h1) begin
          st_next.acc_state = acc_live;
          st_next.acc_settle = 4'h0;
          acc_rise = acc_live;
          acc_fall = ~acc_live;
        end else begin
          st_next.acc_settle = st_reg.acc_settle + 4'h1;
        end
      end else begin
        st_next.acc_settle = 4'h0;
      end
    end

    // The filter output is the held short state; its edges are the events.
    st_next.sht_state = sht_filt;
    sht_rise = sht_filt & ~st_reg.sht_state;
    sht_fall = ~sht_filt & st_reg.sht_state;
    acc_set = mbcd_event_sel(st_reg.acc_pol, acc_rise, acc_fall);
    sht_set = mbcd_event_sel(st_reg.sht_pol, sht_rise, sht_fall);
    st_next.acc_ev = acc_set;
    st_next.sht_ev = sht_set;
    st_next.gpio = st_reg.gpio_sel ? st_reg.sht_state : st_reg.acc_state;

    // Register writes; flag clears are write-one-to-clear and lose to a new set.
    if (reg_wr) begin
      st_next.ack = 1'b1;
      case (reg_addr)
        `MBCD_ADDR_PWR1: begin
          st_next.bias_en = reg_wdata[`MBCD_BIT_BIAS_EN];
          st_next.system_clock_en = reg_wdata[`MBCD_BIT_SYSTEM_CLOCK_EN];
        end
        `MBCD_ADDR_LVL: begin
          st_next.bias_lvl = reg_wdata[`MBCD_BIT_BIAS_LVL];
        end
        `MBCD_ADDR_ACC: begin
          st_next.acc_thr = reg_wdata[`MBCD_ACC_THR_HI:`MBCD_ACC_THR_LO];
          st_next.sht_thr = reg_wdata[`MBCD_SHT_THR_HI:`MBCD_SHT_THR_LO];
          st_next.det_en = reg_wdata[`MBCD_BIT_DET_EN];
        end
        `MBCD_ADDR_IRQ: begin
          st_next.acc_pol = reg_wdata[`MBCD_BIT_ACC_POL];
          st_next.sht_pol = reg_wdata[`MBCD_BIT_SHT_POL];
          st_next.gpio_sel = reg_wdata[`MBCD_BIT_GPIO_SEL];
          clr = reg_wdata;
        end
        default: begin
          // Unmapped addresses are acknowledged so the host never waits on a hole.
          st_next.ack = 1'b1;
        end
      endcase
    end
    st_next.acc_irq = mbcd_flag_next(acc_set, st_reg.acc_irq, clr[`MBCD_BIT_ACC_IRQ]);
    st_next.sht_irq = mbcd_flag_next(sht_set, st_reg.sht_irq, clr[`MBCD_BIT_SHT_IRQ]);
    // The enable follows the new bias bit on the same edge as the drive level, so the
    // pin never floats while the drive says on, nor drives while it says off.
    st_next.oe_n = ~st_next.bias_en;

    // Reads register their word, so read data stands until the next read.
    if (reg_rd) begin
      st_next.ack = 1'b1;
      st_next.rdata = `MBCD_RST_ZERO;
      case (reg_addr)
        `MBCD_ADDR_PWR1: begin
          st_next.rdata = mbcd_pwr1_word(st_reg);
        end
        `MBCD_ADDR_LVL: begin
          st_next.rdata = mbcd_lvl_word(st_reg);
        end
        `MBCD_ADDR_ACC: begin
          st_next.rdata = mbcd_acc_word(st_reg);
        end
        `MBCD_ADDR_IRQ: begin
          st_next.rdata = mbcd_irq_word(st_reg);
        end
        default: begin
          st_next.rdata = `MBCD_RST_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      // Level select resets high and the pin floats; every other field resets to zero.
      st_reg <= '0;
      st_reg.bias_lvl <= `MBCD_RST_LVL;
      st_reg.oe_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata = st_reg.rdata;
  assign reg_ack = st_reg.ack;
  assign mic_bias_output_drive = st_reg.bias_en;
  assign mic_bias_output_oe_n = st_reg.oe_n;
  assign bias_level_select = st_reg.bias_lvl;
  assign current_detect_enable = st_reg.det_en;
  assign accessory_threshold = st_reg.acc_thr;
  assign short_threshold = st_reg.sht_thr;
  assign accessory_event = st_reg.acc_ev;
  assign short_event = st_reg.sht_ev;
  assign gpio_detect_level = st_reg.gpio;
endmodule : mbcd_top

/* mbcd_mic_model.sv */
/*
 Electret microphone with hook switch, turning bias current into comparator levels.
 Assumes the bench sets inserted and pressed and the block drives the threshold codes.
*/
`timescale 1ns/1ps
module mbcd_mic_model (
  input wire logic drive,
  input wire logic oe_n,
  input wire logic [2:0] acc_thr,
  input wire logic [1:0] sht_thr,
  input wire logic inserted,
  input wire logic pressed,
  output logic acc_above,
  output logic sht_above
);
  int cur;
  int acc_ua[8] = '{64, 166, 375, 475, 575, 680, 885, 990};
  int sht_ua[4] = '{515, 680, 1050, 1215};
  // A floating bias pin sources nothing, so an undriven pin reads as no accessory.
  always_comb begin
    cur = (drive && !oe_n && inserted) ? (pressed ? 1100 : 500) : 0;
    acc_above = cur > acc_ua[acc_thr];
    sht_above = cur > sht_ua[sht_thr];
  end
endmodule : mbcd_mic_model

/* mbcd_top_props.sv */
/*
 Port checker for mbcd_top.
 Assumes it is bound into mbcd_top and sees one clock domain.
*/
`timescale 1ns/1ps
module mbcd_top_props (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_ack,
  input wire logic clock_source_present,
  input wire logic comp_sht_above,
  input wire logic mic_bias_output_drive,
  input wire logic mic_bias_output_oe_n,
  input wire logic bias_level_select,
  input wire logic current_detect_enable,
  input wire logic [2:0] accessory_threshold,
  input wire logic [1:0] short_threshold,
  input wire logic accessory_event,
  input wire logic short_event
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [16:0] hi_run;
  logic [7:0] ctrl_word;
  assign ctrl_word = {accessory_threshold, short_threshold, bias_level_select,
    current_detect_enable, mic_bias_output_drive};
  // Saturates so a long press never wraps back to a short-looking run.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hi_run <= 17'h00000;
    end else if (!comp_sht_above) begin
      hi_run <= 17'h00000;
    end else if (hi_run != 17'h1ffff) begin
      hi_run <= hi_run + 17'h00001;
    end
  end
  sequence s_quiet2; !reg_wr [*2]; endsequence
  sequence s_det_off; !current_detect_enable [*5]; endsequence
  sequence s_clk_off; !clock_source_present [*5]; endsequence
  a_bias_hiz: assert property (mic_bias_output_oe_n == !mic_bias_output_drive)
    else $error("bias pin enable disagrees with drive");
  a_ack_follows: assert property ((reg_wr || reg_rd) |=> reg_ack)
    else $error("access not acknowledged");
  a_ack_quiet: assert property (!(reg_wr || reg_rd) |=> !reg_ack)
    else $error("acknowledge without access");
  a_ctrl_hold: assert property (s_quiet2 |=> $stable(ctrl_word))
    else $error("control output moved without a write");
  a_acc_pulse: assert property (accessory_event |=> !accessory_event)
    else $error("accessory event longer than one cycle");
  a_sht_pulse: assert property (short_event |=> !short_event)
    else $error("short event longer than one cycle");
  a_det_gate: assert property (s_det_off |-> !accessory_event && !short_event)
    else $error("event while detection disabled");
  a_clk_gate: assert property (s_clk_off |-> !accessory_event && !short_event)
    else $error("event without a clock source");
  a_short_filter: assert property (short_event |-> hi_run >= 17'h02328 || hi_run == 17'h00000)
    else $error("short event before ten high measurements");
endmodule : mbcd_top_props
bind mbcd_top mbcd_top_props i_mbcd_top_props (.clock, .rst_n, .reg_wr, .reg_rd, .reg_ack,
  .clock_source_present, .comp_sht_above, .mic_bias_output_drive, .mic_bias_output_oe_n,
  .bias_level_select, .current_detect_enable, .accessory_threshold, .short_threshold,
  .accessory_event, .short_event);

/* mbcd_top_tb_top.sv */
/*
 Self-checking bench for mbcd_top with the microphone model on its comparator inputs.
 Assumes a 100 MHz clock and the register map of the block's header.
*/
`timescale 1ns/1ps
module mbcd_top_tb_top;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic clock_source_present = 1'b0;
  logic inserted = 1'b0;
  logic pressed = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata, rd;
  logic reg_ack, comp_acc_above, comp_sht_above, mic_bias_output_drive, mic_bias_output_oe_n;
  logic bias_level_select, current_detect_enable, accessory_event, short_event, gpio_detect_level;
  logic [2:0] accessory_threshold;
  logic [1:0] short_threshold;
  int fail_count = 0, check_count = 0, acc_n = 0, sht_n = 0;
  mbcd_top i_mbcd_top (.clock, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_ack, .clock_source_present, .comp_acc_above, .comp_sht_above, .mic_bias_output_drive,
    .mic_bias_output_oe_n, .bias_level_select, .current_detect_enable, .accessory_threshold,
    .short_threshold, .accessory_event, .short_event, .gpio_detect_level);
  mbcd_mic_model i_mbcd_mic_model (.drive(mic_bias_output_drive), .oe_n(mic_bias_output_oe_n),
    .acc_thr(accessory_threshold), .sht_thr(short_threshold), .inserted, .pressed,
    .acc_above(comp_acc_above), .sht_above(comp_sht_above));
  always #5 clock = ~clock;
  // Counted mid-cycle, where each one-cycle pulse has settled.
  always @(negedge clock) begin
    if (accessory_event === 1'b1) acc_n++;
    if (short_event === 1'b1) sht_n++;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step
  // Strobes are single-cycle; address and data stay put until the acknowledge is seen.
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = d;
    step(1);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    check({15'h0000, reg_ack}, 16'h0001);
    rd = reg_rdata;
    step(1);
  endtask : acc
  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    acc(1'b0, a, 16'h0000);
    check(rd, exp);
  endtask : rchk
  task automatic wait_for(input bit is_acc, input int want, input int lim);
    for (int i = 0; i < lim && (is_acc ? acc_n : sht_n) < want; i++) step(1);
  endtask : wait_for
  task automatic t_reset;
    check({14'h0000, mic_bias_output_oe_n, bias_level_select}, 16'h0003);
    rchk(8'h19, 16'h0000);
    rchk(8'h30, 16'h0001);
    rchk(8'h31, 16'h0000);
    rchk(8'h32, 16'h0000);
    acc(1'b1, 8'h7f, 16'hffff);
    rchk(8'h7f, 16'h0000);
  endtask : t_reset
  task automatic t_bias;
    acc(1'b1, 8'h19, 16'h0002);
    check({14'h0000, mic_bias_output_oe_n, mic_bias_output_drive}, 16'h0001);
    acc(1'b1, 8'h30, 16'h0000);
    check({15'h0000, bias_level_select}, 16'h0000);
    acc(1'b1, 8'h30, 16'h0001);
    check({15'h0000, bias_level_select}, 16'h0001);
  endtask : t_bias
  task automatic t_thr;
    inserted = 1'b1;
    pressed = 1'b1;
    for (int c = 0; c < 8; c++) begin
      acc(1'b1, 8'h31, {1'b0, c[2:0], c[1:0], 10'h000});
      check({11'h000, accessory_threshold, short_threshold}, {11'h000, c[2:0], c[1:0]});
      rchk(8'h31, {1'b0, c[2:0], c[1:0], 10'h000});
    end
  endtask : t_thr
  task automatic t_status;
    acc(1'b1, 8'h31, 16'h3a00);
    step(5);
    rchk(8'h31, 16'h3ac0);
    acc(1'b1, 8'h31, 16'h4e00);
    step(5);
    rchk(8'h31, 16'h4e80);
    pressed = 1'b0;
    step(5);
    rchk(8'h31, 16'h4e00);
  endtask : t_status
  task automatic t_press;
    acc(1'b1, 8'h32, 16'h0000);
    acc(1'b1, 8'h19, 16'h0006);
    acc(1'b1, 8'h31, 16'h3a00);
    pressed = 1'b1;
    step(3000);
    check(16'(acc_n + sht_n), 16'h0000);
    clock_source_present = 1'b1;
    wait_for(1'b1, 1, 6000);
    check(16'(acc_n), 16'h0001);
    check({15'h0000, gpio_detect_level}, 16'h0001);
    rchk(8'h32, 16'h0010);
    wait_for(1'b0, 1, 11000);
    check(16'(sht_n), 16'h0001);
    rchk(8'h32, 16'h0030);
  endtask : t_press
  task automatic t_release;
    step(1000);
    acc(1'b1, 8'h32, 16'h0033);
    rchk(8'h32, 16'h0003);
    pressed = 1'b0;
    wait_for(1'b0, 2, 3000);
    check(16'(sht_n), 16'h0002);
    acc(1'b1, 8'h32, 16'h000b);
    check({15'h0000, gpio_detect_level}, 16'h0000);
    rchk(8'h32, 16'h002b);
    acc(1'b1, 8'h32, 16'h0003);
    inserted = 1'b0;
    wait_for(1'b1, 2, 6000);
    check(16'(acc_n), 16'h0002);
    check({15'h0000, gpio_detect_level}, 16'h0000);
    rchk(8'h32, 16'h0033);
  endtask : t_release
  task automatic complete_run;
    if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  initial begin
    step(2);
    rst_n = 1'b1;
    step(1);
    t_reset();
    t_bias();
    t_thr();
    t_status();
    t_press();
    t_release();
    complete_run();
  end
  // Sized for roughly 20k cycles of detection waits, with margin.
  initial begin
    #400000;
    fail_count++;
    complete_run();
  end
endmodule : mbcd_top_tb_top
